//--- vec_pkg.sv
package vec_pkg;
   // Table geometry
   localparam int          NUM_IRQ        = 44;   // Peripheral lines
   localparam int          NUM_EXC        = 16;   // Core exception slots
   localparam int          VEC_W          = 6;    // Vector number width
   localparam int          PRIO_W         = 3;    // Configurable 0..7
   localparam logic [31:0] RESET_BASE     = 32'h0000_0000;
   localparam logic [31:0] BASE_MIN       = 32'h0000_0100;
   localparam logic [31:0] BASE_MAX       = 32'h3fff_ff00;
   localparam int          ALIGN_BITS     = 8;    // 256-byte alignment
   localparam logic [PRIO_W-1:0] PRIO_RST = 3'h0;
   localparam logic [5:0]  IRQ_VEC_OFS    = 6'h10; // First peripheral vector
   localparam logic [5:0]  SYSTEM_TICK_EXCEPTION_VEC    = 6'h0f;
   // Interrupt number to source map
   localparam logic [43:0] IRQ_WIRED =
      44'h081_fffc_05bf; // Bits 0-5,7,8,10,18-32,39 wired
   // Exception classes
   typedef enum logic [1:0] {CLS_NONE, CLS_SYSTEM, CLS_ISR, CLS_FIXED} cls_t;
   // Fixed negative priorities encoded as extended rank below 0
   localparam logic [3:0]  RANK_NMI   = 4'h1;
   localparam logic [3:0]  RANK_HARD  = 4'h2;
   localparam logic [3:0]  RANK_RESET = 4'h0;
   localparam logic [3:0]  RANK_PROG  = 4'h3;  // Added to programmable prio
endpackage

//--- prio_pick.sv
`timescale 1ns/1ps
// Finds the most urgent pending exception: lowest rank, lowest number on tie
module prio_pick
   import vec_pkg::*;
#(
   parameter int N = 60
) (
   input  wire logic [N-1:0]   pend,
   input  wire logic [N*4-1:0] rank,
   output logic                any,
   output logic [VEC_W-1:0]    win
);
   logic [3:0] best;   // Rank of current winner
   always_comb begin
      any  = 1'b0;
      win  = '0;
      best = 4'hf;
      // Strict less-than keeps the lower number on equal rank
      for (int i = 0; i < N; i++) begin
         if (pend[i] && (!any || rank[i*4 +: 4] < best)) begin
            any  = 1'b1;
            best = rank[i*4 +: 4];
            win  = VEC_W'(i);
         end
      end
   end
endmodule

//--- exception_vector_mapper.sv
`timescale 1ns/1ps
// Overview of operation
// - Programmable priorities reset to zero
// - Peripheral interrupts start at vector 16, offset 0x40
// - Vector equals interrupt number plus sixteen
// - GPIO A-E on 0-4, F-H on 30-32
// - UART 5, serial 7, I2C 8, PWM 10
// - Watchdog 18, timers 19 to 24
// - Comparators 25-27, sysctl 28, flash 29
// - CAN controller on interrupt 39, vector 55
// - Table: stack pointer then handlers by vector
// - Table base is zero after reset
// - Privileged write relocates base within range
// - Classify system versus interrupt-service exceptions
// - Lower value more urgent, fixed negatives win
// - Equal priority: lowest exception number first
module exception_vector_mapper
   import vec_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   // Named peripheral request lines
   input  wire logic [4:0]             gpio_a_to_e_irq,
   input  wire logic [2:0]             gpio_f_to_h_irq,
   input  wire logic                   uart_irq,
   input  wire logic                   sync_serial_port_zero_irq,
   input  wire logic                   i2c_irq,
   input  wire logic                   pwm_gen0_irq,
   input  wire logic                   watchdog_irq,
   input  wire logic [5:0]             timer_irq,
   input  wire logic [2:0]             comparator_irq,
   input  wire logic                   sysctl_irq,
   input  wire logic                   flash_irq,
   input  wire logic                   can_irq,
   // Core exception requests
   input  wire logic                   nmi_req,
   input  wire logic                   hard_fault_req,
   input  wire logic [2:0]             fault_req,
   input  wire logic                   supervisor_call_exception,
   input  wire logic                   debug_mon_req,
   input  wire logic                   pendable_service_request,
   input  wire logic                   system_tick_exception,
   // Priority programming, one entry per vector
   input  wire logic                   prio_wr,
   input  wire logic [VEC_W-1:0]       prio_vec,
   input  wire logic [PRIO_W-1:0]      prio_val,
   // Table base relocation
   input  wire logic                   table_base_offset_reg_wr,
   input  wire logic                   privileged,
   input  wire logic [31:0]            table_base_offset_reg_wdata,
   // Vector fetch request from the core
   input  wire logic                   fetch_req,
   input  wire logic [VEC_W-1:0]       fetch_vec,
   output logic                        fetch_valid_q,
   output logic [31:0]                 fetch_addr_q,
   output logic                        fetch_mapped_q,
   // Arbitration and status
   output logic                        irq_pending_q,
   output logic [VEC_W-1:0]            top_vec_q,
   output logic [31:0]                 top_addr_q,
   output cls_t                        top_cls_q,
   output logic [31:0]                 table_base_offset_reg,
   output logic [NUM_IRQ-1:0]          irq_lines_q
);
   localparam int NV = NUM_EXC + NUM_IRQ; // Vectors 0..59

   logic [1:0]       rst_sync_q;   // Reset release synchroniser
   logic             rst_ni;       // Internal reset copy
   logic [NUM_IRQ-1:0] irq_d;      // Interrupt lines by number
   logic [NV-1:0]    pend;         // Pending per vector
   logic [NV*4-1:0]  rank;         // Urgency rank per vector
   logic             any;          // Any pending
   logic [VEC_W-1:0] win;          // Most urgent vector
   logic [31:0]      base_q;       // Active table base
   logic [PRIO_W-1:0] irq_priority_level_regs [NV]; // Programmed levels

   // Handler entry address: base plus four times vector
   function automatic logic [31:0] vec_addr(input logic [31:0] b,
                                            input logic [VEC_W-1:0] v);
      vec_addr = b + {24'h0, v, 2'b00};
   endfunction

   // True where a vector has a handler entry
   function automatic logic vec_mapped(input logic [VEC_W-1:0] v);
      if (v < IRQ_VEC_OFS)
         vec_mapped = !(v inside {6'd7, 6'd8, 6'd9, 6'd10, 6'd13});
      else if (int'(v) < NV)
         vec_mapped = IRQ_WIRED[v - IRQ_VEC_OFS];
      else
         vec_mapped = 1'b0;
   endfunction

   // Classify an exception by vector; stack slot and reset stand apart,
   // while the non-maskable request and hard fault count as system
   function automatic cls_t vec_class(input logic [VEC_W-1:0] v);
      if (v <= 6'd1)
         vec_class = CLS_FIXED;
      else if (v < IRQ_VEC_OFS)
         vec_class = CLS_SYSTEM;
      else
         vec_class = CLS_ISR;
   endfunction

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         rst_sync_q <= 2'b00;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_ni = rst_sync_q[1];

   // Map named sources onto interrupt numbers; reserved stay zero
   always_comb begin
      irq_d          = '0;
      irq_d[4:0]     = gpio_a_to_e_irq;
      irq_d[32:30]   = gpio_f_to_h_irq;
      irq_d[5]       = uart_irq;
      irq_d[7]       = sync_serial_port_zero_irq;
      irq_d[8]       = i2c_irq;
      irq_d[10]      = pwm_gen0_irq;
      irq_d[18]      = watchdog_irq;
      irq_d[24:19]   = timer_irq;
      irq_d[27:25]   = comparator_irq;
      irq_d[28]      = sysctl_irq;
      irq_d[29]      = flash_irq;
      irq_d[39]      = can_irq;
   end

   // Registered line image; sources are asynchronous to code flow
   always_ff @(posedge clk or negedge rst_ni) begin
      if (!rst_ni)
         irq_lines_q <= '0;
      else
         irq_lines_q <= irq_d;
   end

   // Priority levels, all zero until software writes one
   always_ff @(posedge clk or negedge rst_ni) begin
      if (!rst_ni) begin
         for (int i = 0; i < NV; i++)
            irq_priority_level_regs[i] <= PRIO_RST;
      end else if (prio_wr && int'(prio_vec) < NV &&
                   prio_vec > 6'd3) begin // Fixed levels stay put
         irq_priority_level_regs[prio_vec] <= prio_val;
      end
   end

   // Pending and rank per vector; fixed ones rank ahead of all levels
   always_comb begin
      pend = '0;
      rank = '0;
      pend[2]  = nmi_req;
      pend[3]  = hard_fault_req;
      pend[6:4] = fault_req;
      pend[11] = supervisor_call_exception;
      pend[12] = debug_mon_req;
      pend[14] = pendable_service_request;
      pend[SYSTEM_TICK_EXCEPTION_VEC] = system_tick_exception;
      pend[NV-1:NUM_EXC] = irq_lines_q & IRQ_WIRED;
      for (int i = 0; i < NV; i++)
         rank[i*4 +: 4] = RANK_PROG + 4'(irq_priority_level_regs[i]);
      rank[2*4 +: 4] = RANK_NMI;
      rank[3*4 +: 4] = RANK_HARD;
      rank[1*4 +: 4] = RANK_RESET;
   end

   prio_pick #(
      .N (NV)
   ) u_pick (
      .pend (pend),
      .rank (rank),
      .any  (any),
      .win  (win)
   );

   // Table base: zero at reset, privileged in-range writes move it
   always_ff @(posedge clk or negedge rst_ni) begin
      if (!rst_ni)
         base_q <= RESET_BASE;
      else if (table_base_offset_reg_wr && privileged &&
               {table_base_offset_reg_wdata[31:ALIGN_BITS], 8'h00}
                  >= BASE_MIN &&
               {table_base_offset_reg_wdata[31:ALIGN_BITS], 8'h00}
                  <= BASE_MAX)
         base_q <= {table_base_offset_reg_wdata[31:ALIGN_BITS],
                    8'h00};
   end

   // Readback copy of the offset register, low bits always zero
   always_ff @(posedge clk or negedge rst_ni) begin
      if (!rst_ni)
         table_base_offset_reg <= RESET_BASE;
      else
         table_base_offset_reg <= base_q;
   end

   // Handler fetch answer one cycle after the request
   always_ff @(posedge clk or negedge rst_ni) begin
      if (!rst_ni) begin
         fetch_valid_q  <= 1'b0;
         fetch_addr_q   <= '0;
         fetch_mapped_q <= 1'b0;
      end else begin
         fetch_valid_q  <= fetch_req;
         if (fetch_req) begin
            fetch_addr_q   <= vec_addr(base_q, fetch_vec);
            fetch_mapped_q <= vec_mapped(fetch_vec) ||
                              fetch_vec == 6'd0;
         end
      end
   end

   // Most urgent pending exception and its entry
   always_ff @(posedge clk or negedge rst_ni) begin
      if (!rst_ni) begin
         irq_pending_q <= 1'b0;
         top_vec_q     <= '0;
         top_addr_q    <= '0;
         top_cls_q     <= CLS_NONE;
      end else begin
         irq_pending_q <= any;
         top_vec_q     <= win;
         top_addr_q    <= vec_addr(base_q, win);
         top_cls_q     <= any ? vec_class(win) : CLS_NONE;
      end
   end
endmodule

//--- evm_chk.sv
`timescale 1ns/1ps
// Port-level watch on fetch, relocation and arbitration outputs
module evm_chk
   import vec_pkg::*;
(
   input wire logic             clk,
   input wire logic             rst_n,
   input wire logic             nmi_req,
   input wire logic             table_base_offset_reg_wr,
   input wire logic             privileged,
   input wire logic             fetch_req,
   input wire logic [VEC_W-1:0] fetch_vec,
   input wire logic             fetch_valid_q,
   input wire logic [31:0]      fetch_addr_q,
   input wire logic             fetch_mapped_q,
   input wire logic             irq_pending_q,
   input wire logic [VEC_W-1:0] top_vec_q,
   input wire cls_t             top_cls_q,
   input wire logic [31:0]      table_base_offset_reg
);
   // Raw reset disables; the synced copy only delays release
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_fetch_valid_pulse: assert property (fetch_req |=> fetch_valid_q)
      else $error("fetch gave no valid pulse");
   a_fetch_valid_drop: assert property
      (fetch_req ##1 !fetch_req |=> !fetch_valid_q)
      else $error("fetch valid longer than one cycle");
   // Readback lags base by one, so it matches the base the fetch used
   a_fetch_addr_calc: assert property (fetch_req |=> fetch_addr_q ==
      table_base_offset_reg + 32'({$past(fetch_vec), 2'b00}))
      else $error("fetch address not base plus four times vector");
   a_reserved_unmapped: assert property (fetch_req && fetch_vec inside
      {6'h07, 6'h08, 6'h09, 6'h0a, 6'h0d, 6'h16, 6'h19} |=> !fetch_mapped_q)
      else $error("reserved vector reported as mapped");
   a_base_aligned: assert property
      (table_base_offset_reg[7:0] == 8'h00)
      else $error("base low bits not zero");
   a_base_range: assert property
      (table_base_offset_reg == RESET_BASE ||
      (table_base_offset_reg >= BASE_MIN &&
       table_base_offset_reg <= BASE_MAX))
      else $error("base outside legal range");
   a_unpriv_write_ignored: assert property
      (table_base_offset_reg_wr && !privileged |=> ##1
      $stable(table_base_offset_reg))
      else $error("unprivileged write moved the base");
   a_nmi_wins: assert property (nmi_req |=> top_vec_q == 6'h02)
      else $error("non-maskable request did not win");
   a_isr_class: assert property
      (irq_pending_q && top_vec_q >= IRQ_VEC_OFS |-> top_cls_q == CLS_ISR)
      else $error("peripheral vector not classed as interrupt-service");
   a_core_class: assert property
      (irq_pending_q && top_vec_q < IRQ_VEC_OFS |-> top_cls_q == CLS_SYSTEM)
      else $error("core exception not classed as system");
   c_fetch: cover property (fetch_req ##1 fetch_valid_q);
   c_core: cover property (irq_pending_q && top_cls_q == CLS_SYSTEM);
   c_reloc: cover property (table_base_offset_reg_wr && privileged);
   c_isr: cover property (irq_pending_q && top_cls_q == CLS_ISR);
endmodule
bind exception_vector_mapper evm_chk u_chk (
   .clk                         (clk),
   .rst_n                       (rst_n),
   .nmi_req                     (nmi_req),
   .table_base_offset_reg_wr    (table_base_offset_reg_wr),
   .privileged                  (privileged),
   .fetch_req                   (fetch_req),
   .fetch_vec                   (fetch_vec),
   .fetch_valid_q               (fetch_valid_q),
   .fetch_addr_q                (fetch_addr_q),
   .fetch_mapped_q              (fetch_mapped_q),
   .irq_pending_q               (irq_pending_q),
   .top_vec_q                   (top_vec_q),
   .top_cls_q                   (top_cls_q),
   .table_base_offset_reg       (table_base_offset_reg)
);

//--- periph_src.sv
`timescale 1ns/1ps
// Peripheral sources: each raises a level at its interrupt number's bit
module periph_src (
   input  wire logic [43:0] req,
   output logic      [4:0]  ga,
   output logic      [2:0]  gf,
   output logic      [5:0]  tmr,
   output logic      [2:0]  cmp,
   output logic      [7:0]  one
);
   assign ga  = req[4:0];
   assign gf  = req[32:30];
   assign tmr = req[24:19];
   assign cmp = req[27:25];
   // Single lines, uart at bit 0 up to can at bit 7; reserved bits unused
   assign one = {req[39], req[29:28], req[18],
                 req[10], req[8:7], req[5]};
endmodule

//--- tb.sv
`timescale 1ns/1ps
module tb;
   import vec_pkg::*;
   localparam logic [43:0] WIRED = 44'h081_fffc_05bf; // Sourced numbers
   logic        clk = 1'b0, rst_n = 1'b0, nmi = 1'b0, tick = 1'b0;
   logic        pwr = 1'b0, bwr = 1'b0, priv = 1'b0, freq = 1'b0;
   logic        hf = 1'b0, sv = 1'b0, dbg = 1'b0, pv = 1'b0, ip;
   logic [2:0]  flt = '0;
   logic [43:0] req = '0;
   logic [5:0]  pvec = '0, fvec = '0;
   logic [2:0]  pval = '0;
   logic [31:0] bdat = '0;
   int          num_errors = 0, total_checks = 0, cycles = 0;
   logic [4:0]  ga;
   logic [2:0]  gf, cmp;
   logic [5:0]  tmr, tv;
   logic [7:0]  one;
   logic        fv, fm;
   logic [31:0] fa, ta, base;
   logic [43:0] lines;
   cls_t        tc;
   always #5 clk = ~clk;
   periph_src src (.req(req), .ga(ga), .gf(gf), .tmr(tmr), .cmp(cmp),
      .one(one));
   exception_vector_mapper DUT (.clk(clk), .rst_n(rst_n),
      .gpio_a_to_e_irq(ga), .gpio_f_to_h_irq(gf), .uart_irq(one[0]),
      .sync_serial_port_zero_irq(one[1]), .i2c_irq(one[2]),
      .pwm_gen0_irq(one[3]), .watchdog_irq(one[4]), .timer_irq(tmr),
      .comparator_irq(cmp), .sysctl_irq(one[5]), .flash_irq(one[6]),
      .can_irq(one[7]), .nmi_req(nmi), .hard_fault_req(hf),
      .fault_req(flt), .supervisor_call_exception(sv),
      .debug_mon_req(dbg), .pendable_service_request(pv),
      .system_tick_exception(tick), .prio_wr(pwr), .prio_vec(pvec),
      .prio_val(pval), .table_base_offset_reg_wr(bwr), .privileged(priv),
      .table_base_offset_reg_wdata(bdat), .fetch_req(freq),
      .fetch_vec(fvec), .fetch_valid_q(fv), .fetch_addr_q(fa),
      .fetch_mapped_q(fm), .irq_pending_q(ip), .top_vec_q(tv),
      .top_addr_q(ta), .top_cls_q(tc), .table_base_offset_reg(base),
      .irq_lines_q(lines));
   // One compare, counted; four-state equality so unknowns fail
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp)
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      if (seen !== exp)
         num_errors++;
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask
   // One fetch; answer stands in the cycle after the taking edge
   task automatic fetch(input logic [5:0] v, input logic [31:0] b);
      logic m;
      m = (v < 6'h10) ? !(v inside {6'h07, 6'h08, 6'h09, 6'h0a, 6'h0d})
                      : WIRED[v - 6'h10];
      fvec = v;
      freq = 1'b1;
      step(1);
      freq = 1'b0;
      check(fv, 1'b1);
      check(fa, b + {v, 2'b00});
      check(fm, m);
      check(fa[1:0], 2'b00);         // Entry addresses are word aligned
      step(1);
   endtask
   // Base write, then wait for the lagging readback
   task automatic wbase(input logic [31:0] d, input logic p,
                        input logic [31:0] e);
      bdat = d;
      priv = p;
      bwr = 1'b1;
      step(1);
      bwr = 1'b0;
      step(2);
      check(base, e);
   endtask
   task automatic t_fetch_all;
      check(base, 32'h0000_0000);
      for (int v = 0; v < 60; v++)
         fetch(6'(v), 32'h0000_0000);
   endtask
   task automatic t_relocate;
      wbase(32'h2000_0000, 1'b0, 32'h0000_0000);
      wbase(32'h2000_01ff, 1'b1, 32'h2000_0100);
      fetch(6'd55, 32'h2000_0100);
      wbase(32'h4000_0000, 1'b1, 32'h2000_0100);
      wbase(32'h0000_00ff, 1'b1, 32'h2000_0100);
      wbase(32'h3fff_ffff, 1'b1, 32'h3fff_ff00);
      fetch(6'd15, 32'h3fff_ff00);
   endtask
   // Each number alone: line image and winning vector
   task automatic t_lines;
      for (int n = 0; n < 44; n++) begin
         req = 44'h1 << n;
         step(3);
         check(lines, WIRED & req);
         check(ip, WIRED[n]);
         if (WIRED[n]) begin
            check(tv, n + 16);
            check(tc, CLS_ISR);
         end
      end
      req = '0;
   endtask
   // Core exceptions alone, then together: fixed levels win
   task automatic t_core;
      logic [5:0] want [7] = '{6'd3, 6'd6, 6'd5, 6'd4, 6'd11, 6'd12, 6'd14};
      for (int k = 0; k < 7; k++) begin
         {hf, flt, sv, dbg, pv} = 7'h40 >> k;
         step(2);
         check(tv, want[k]);
         check(tc, CLS_SYSTEM);
         check(ip, 1'b1);
      end
      {hf, flt, sv, dbg, pv} = 7'h7f;
      step(2);
      check(tv, 6'd3);
      nmi = 1'b1;
      step(2);
      check(tv, 6'd2);
      check(tc, CLS_SYSTEM);
      {hf, flt, sv, dbg, pv} = 7'h00;
      nmi = 1'b0;
      step(2);
      check(ip, 1'b0);
   endtask
   task automatic t_prio;
      req = 44'h080_0000_0001;
      step(3);
      check(tv, 6'd16);
      pvec = 6'd16;
      pval = 3'h7;
      pwr = 1'b1;
      step(1);
      pwr = 1'b0;
      step(3);
      check(tv, 6'd55);
      tick = 1'b1;
      step(3);
      check(tv, SYSTEM_TICK_EXCEPTION_VEC);
      check(tc, CLS_SYSTEM);
      check(ta, 32'h3fff_ff3c);
      nmi = 1'b1;
      step(3);
      check(tv, 6'd2);
      check(tc, CLS_SYSTEM);
   endtask
   task automatic close_out;
      $display("Checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Hang guard, far above the roughly 320 cycles needed
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         close_out;
      end
   end
   initial begin
      step(12);
      rst_n = 1'b1;
      step(3);
      t_fetch_all;
      t_relocate;
      t_lines;
      t_core;
      t_prio;
      close_out;
   end
endmodule
